// *** bpwc_pkg.sv ***
// Package for the prefetch window and bridge control block: offsets, resets, fields, types
package bpwc_pkg;

  // ****************************************
  // Configuration offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] PREF_BASE_LO_OFF = 8'h24;
  localparam logic [7:0] PREF_BASE_HI_OFF = 8'h25;
  localparam logic [7:0] PREF_LIMIT_LO_OFF = 8'h26;
  localparam logic [7:0] PREF_LIMIT_HI_OFF = 8'h27;
  localparam logic [7:0] BRIDGE_CTRL_OFF = 8'h3e;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [15:0] PREF_BASE_RST = 16'hfff0;
  localparam logic [15:0] PREF_LIMIT_RST = 16'h0000;
  localparam logic [7:0] BRIDGE_CTRL_RST = 8'h00;
  localparam int FIELD_LSB = 4;
  localparam int BCTRL_BACK_TO_BACK_BIT = 7;
  localparam int BCTRL_SEC_RESET_BIT = 6;
  localparam int BCTRL_MASTER_ABORT_BIT = 5;
  localparam int BCTRL_DISPLAY_BIT = 3;
  localparam int BCTRL_ALIAS_BIT = 2;
  localparam int BCTRL_SEC_ERR_BIT = 1;
  localparam int BCTRL_PARITY_BIT = 0;

  // ****************************************
  // Legacy display address ranges and master abort read data
  // ****************************************
  localparam logic [31:0] DISP_MEM_LO = 32'h000a_0000;
  localparam logic [31:0] DISP_MEM_HI = 32'h000b_ffff;
  localparam logic [31:0] MONO_MEM_LO = 32'h000b_0000;
  localparam logic [31:0] MONO_MEM_HI = 32'h000b_7fff;
  localparam logic [31:0] MONO_IO_LO = 32'h0000_03b0;
  localparam logic [31:0] MONO_IO_HI = 32'h0000_03bb;
  localparam logic [31:0] MONO_IO_EXTRA = 32'h0000_03bf;
  localparam logic [31:0] COLOR_IO_LO = 32'h0000_03c0;
  localparam logic [31:0] COLOR_IO_HI = 32'h0000_03df;
  localparam logic [31:0] MASTER_ABORT_DATA = 32'hffff_ffff;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } bpwc_req_s;

  typedef struct packed {
    logic valid;
    logic to_secondary;
    logic prefetchable;
  } bpwc_route_s;

endpackage

// *** bpwc_legacy_decode.sv ***
// Legacy display address classifier for the bridge router
`timescale 1ns/100ps

module bpwc_legacy_decode (
  input wire logic is_io,
  input wire logic [31:0] addr,
  output logic mono_hit,
  output logic color_hit
);

  // ****************************************
  // Range compare
  // ****************************************
  always_comb begin
    mono_hit = 1'b0;
    color_hit = 1'b0;
    if (is_io) begin
      mono_hit = ((addr >= bpwc_pkg::MONO_IO_LO) && (addr <= bpwc_pkg::MONO_IO_HI)) ||
                 (addr == bpwc_pkg::MONO_IO_EXTRA);
      color_hit = (addr >= bpwc_pkg::COLOR_IO_LO) && (addr <= bpwc_pkg::COLOR_IO_HI);
    end else begin
      // Mono buffer sits inside the display aperture, so it is carved out first
      mono_hit = (addr >= bpwc_pkg::MONO_MEM_LO) && (addr <= bpwc_pkg::MONO_MEM_HI);
      color_hit = (addr >= bpwc_pkg::DISP_MEM_LO) && (addr <= bpwc_pkg::DISP_MEM_HI) && !mono_hit;
    end
  end

endmodule // bpwc_legacy_decode

// *** bpwc_top.sv ***
// Prefetch window decode, bridge control register and secondary side routing
`timescale 1ns/100ps


module bpwc_top (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire bpwc_pkg::bpwc_req_s REQ,
  input wire logic IO_WINDOW_HIT,
  input wire logic NP_WINDOW_HIT,
  input wire logic MONO_ADAPTER_PRESENT,
  output bpwc_pkg::bpwc_route_s ROUTE,
  output logic ILLEGAL_DISPLAY_CFG,
  input wire logic SEC_DONE,
  input wire logic SEC_IS_READ,
  input wire logic SEC_MASTER_ABORT,
  input wire logic [31:0] SEC_RDATA,
  output logic [31:0] CPU_RDATA,
  output logic CPU_RVALID,
  output logic CPU_WR_COMMIT,
  input wire logic SEC_PARITY_ERR,
  input wire logic OTHER_ERR,
  input wire logic GLOBAL_ERROR_MESSAGE_ENABLE,
  output logic HUB_ERR_MSG
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [11:0] prefetch_base_field;
    logic [11:0] prefetch_limit_field;
    logic legacy_display_route_enable;
    logic legacy_io_alias_filter;
    logic parity_error_report_enable;
    logic [7:0] rdata;
    logic rvalid;
    bpwc_pkg::bpwc_route_s route;
    logic illegal;
    logic [31:0] cpu_rdata;
    logic cpu_rvalid;
    logic wr_commit;
    logic err_msg;
  } bpwc_state_s;

  localparam bpwc_state_s STATE_RST = '{
    prefetch_base_field: bpwc_pkg::PREF_BASE_RST[15:4],
    prefetch_limit_field: bpwc_pkg::PREF_LIMIT_RST[15:4],
    legacy_display_route_enable: bpwc_pkg::BRIDGE_CTRL_RST[bpwc_pkg::BCTRL_DISPLAY_BIT],
    legacy_io_alias_filter: bpwc_pkg::BRIDGE_CTRL_RST[bpwc_pkg::BCTRL_ALIAS_BIT],
    parity_error_report_enable: bpwc_pkg::BRIDGE_CTRL_RST[bpwc_pkg::BCTRL_PARITY_BIT],
    rdata: 8'h00,
    rvalid: 1'b0,
    route: '0,
    illegal: 1'b0,
    cpu_rdata: 32'h0000_0000,
    cpu_rvalid: 1'b0,
    wr_commit: 1'b0,
    err_msg: 1'b0
  };

  bpwc_state_s state_q;
  bpwc_state_s state_d;
  logic mono_hit;
  logic color_hit;
  logic pref_hit;
  logic alias_hit;
  logic [15:0] base_reg;
  logic [15:0] limit_reg;
  logic [7:0] bctrl_reg;

  // ****************************************
  // Legacy display classifier
  // ****************************************
  bpwc_legacy_decode u_legacy (
    .is_io(REQ.is_io),
    .addr(REQ.addr),
    .mono_hit(mono_hit),
    .color_hit(color_hit)
  );

  // ****************************************
  // Register images and window compare
  // ****************************************
  always_comb begin
    base_reg = {state_q.prefetch_base_field, 4'h0};
    limit_reg = {state_q.prefetch_limit_field, 4'h0};
    bctrl_reg = 8'h00;
    bctrl_reg[bpwc_pkg::BCTRL_DISPLAY_BIT] = state_q.legacy_display_route_enable;
    bctrl_reg[bpwc_pkg::BCTRL_ALIAS_BIT] = state_q.legacy_io_alias_filter;
    bctrl_reg[bpwc_pkg::BCTRL_PARITY_BIT] = state_q.parity_error_report_enable;
    // Comparing only A[31:20] is the same as base low bits zero and limit low bits ones
    pref_hit = !REQ.is_io && (REQ.addr[31:20] >= state_q.prefetch_base_field) &&
               (REQ.addr[31:20] <= state_q.prefetch_limit_field);
    alias_hit = REQ.is_io && (REQ.addr[9:8] != 2'b00);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    state_d.route.valid = 1'b0;
    state_d.cpu_rvalid = 1'b0;
    state_d.wr_commit = 1'b0;
    state_d.err_msg = 1'b0;

    // Configuration writes, one byte per access
    if (CFG_WR) begin
      if (CFG_ADDR == bpwc_pkg::PREF_BASE_LO_OFF) begin
        state_d.prefetch_base_field[3:0] = CFG_WDATA[7:4];
      end else if (CFG_ADDR == bpwc_pkg::PREF_BASE_HI_OFF) begin
        state_d.prefetch_base_field[11:4] = CFG_WDATA;
      end else if (CFG_ADDR == bpwc_pkg::PREF_LIMIT_LO_OFF) begin
        state_d.prefetch_limit_field[3:0] = CFG_WDATA[7:4];
      end else if (CFG_ADDR == bpwc_pkg::PREF_LIMIT_HI_OFF) begin
        state_d.prefetch_limit_field[11:4] = CFG_WDATA;
      end else if (CFG_ADDR == bpwc_pkg::BRIDGE_CTRL_OFF) begin
        state_d.legacy_display_route_enable = CFG_WDATA[bpwc_pkg::BCTRL_DISPLAY_BIT];
        state_d.legacy_io_alias_filter = CFG_WDATA[bpwc_pkg::BCTRL_ALIAS_BIT];
        state_d.parity_error_report_enable = CFG_WDATA[bpwc_pkg::BCTRL_PARITY_BIT];
      end
    end

    // Configuration reads; unmapped offsets read zero
    if (CFG_RD) begin
      state_d.rvalid = 1'b1;
      if (CFG_ADDR == bpwc_pkg::PREF_BASE_LO_OFF) begin
        state_d.rdata = base_reg[7:0];
      end else if (CFG_ADDR == bpwc_pkg::PREF_BASE_HI_OFF) begin
        state_d.rdata = base_reg[15:8];
      end else if (CFG_ADDR == bpwc_pkg::PREF_LIMIT_LO_OFF) begin
        state_d.rdata = limit_reg[7:0];
      end else if (CFG_ADDR == bpwc_pkg::PREF_LIMIT_HI_OFF) begin
        state_d.rdata = limit_reg[15:8];
      end else if (CFG_ADDR == bpwc_pkg::BRIDGE_CTRL_OFF) begin
        state_d.rdata = bctrl_reg;
      end else begin
        state_d.rdata = 8'h00;
      end
    end

    // Illegal display setting is reported, routing still falls back to the hub
    state_d.illegal = !state_q.legacy_display_route_enable && MONO_ADAPTER_PRESENT;

    // Processor request routing, answered one cycle later
    if (REQ.valid) begin
      state_d.route.valid = 1'b1;
      state_d.route.to_secondary = 1'b0;
      state_d.route.prefetchable = 1'b0;
      if (mono_hit) begin
        state_d.route.to_secondary = 1'b0;
      end else if (color_hit) begin
        state_d.route.to_secondary = state_q.legacy_display_route_enable;
      end else if (REQ.is_io) begin
        // Alias filter only narrows the window, it never widens it
        state_d.route.to_secondary = IO_WINDOW_HIT && !(state_q.legacy_io_alias_filter && alias_hit);
      end else if (pref_hit) begin
        state_d.route.to_secondary = 1'b1;
        state_d.route.prefetchable = 1'b1;
      end else begin
        state_d.route.to_secondary = NP_WINDOW_HIT;
      end
    end

    // Secondary completions; bit 5 is fixed at zero so aborts never propagate as errors
    if (SEC_DONE) begin
      if (SEC_IS_READ) begin
        state_d.cpu_rvalid = 1'b1;
        state_d.cpu_rdata = SEC_MASTER_ABORT ? bpwc_pkg::MASTER_ABORT_DATA : SEC_RDATA;
      end else begin
        state_d.wr_commit = !SEC_MASTER_ABORT;
      end
    end

    // Hub error messaging; no secondary error pin exists, so nothing else is forwarded
    state_d.err_msg = GLOBAL_ERROR_MESSAGE_ENABLE &&
                      (OTHER_ERR || (SEC_PARITY_ERR && state_q.parity_error_report_enable));
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign CFG_RDATA = state_q.rdata;
  assign CFG_RVALID = state_q.rvalid;
  assign ROUTE = state_q.route;
  assign ILLEGAL_DISPLAY_CFG = state_q.illegal;
  assign CPU_RDATA = state_q.cpu_rdata;
  assign CPU_RVALID = state_q.cpu_rvalid;
  assign CPU_WR_COMMIT = state_q.wr_commit;
  assign HUB_ERR_MSG = state_q.err_msg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_pref_route;
    REQ.valid && !REQ.is_io && !mono_hit && !color_hit &&
    (REQ.addr[31:20] >= state_q.prefetch_base_field) && (REQ.addr[31:20] <= state_q.prefetch_limit_field)
    |=> ROUTE.valid && ROUTE.to_secondary && ROUTE.prefetchable;
  endproperty
  a_pref_route: assert property (p_pref_route) else $error("prefetch window hit not routed");

  property p_base_readback;
    CFG_WR && (CFG_ADDR == bpwc_pkg::PREF_BASE_HI_OFF) ##1 CFG_RD && !CFG_WR &&
    (CFG_ADDR == bpwc_pkg::PREF_BASE_HI_OFF) |=> CFG_RVALID && (CFG_RDATA == $past(CFG_WDATA, 2));
  endproperty
  a_base_readback: assert property (p_base_readback) else $error("base high byte readback wrong");

  property p_low_zero;
    $past(CFG_RD) && (($past(CFG_ADDR) == bpwc_pkg::PREF_BASE_LO_OFF) ||
    ($past(CFG_ADDR) == bpwc_pkg::PREF_LIMIT_LO_OFF)) |-> (CFG_RDATA[3:0] == 4'h0);
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("reserved nibble not zero");

  property p_limit_edge;
    REQ.valid && !REQ.is_io && !mono_hit && !color_hit && !NP_WINDOW_HIT &&
    (REQ.addr[31:20] == state_q.prefetch_limit_field) && (REQ.addr[19:0] == 20'hfffff) &&
    (state_q.prefetch_base_field <= state_q.prefetch_limit_field) |=> ROUTE.prefetchable;
  endproperty
  a_limit_edge: assert property (p_limit_edge) else $error("limit top address missed");

  property p_ctrl_fixed;
    $past(CFG_RD) && ($past(CFG_ADDR) == bpwc_pkg::BRIDGE_CTRL_OFF) |->
    (CFG_RDATA[7:4] == 4'h0) && !CFG_RDATA[bpwc_pkg::BCTRL_SEC_ERR_BIT];
  endproperty
  a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("fixed control bits not zero");

  property p_empty_window;
    REQ.valid && (state_q.prefetch_base_field > state_q.prefetch_limit_field) |=> !ROUTE.prefetchable;
  endproperty
  a_empty_window: assert property (p_empty_window) else $error("empty window matched");

  property p_mono_hub;
    REQ.valid && mono_hit |=> ROUTE.valid && !ROUTE.to_secondary;
  endproperty
  a_mono_hub: assert property (p_mono_hub) else $error("mono access left the hub");

  property p_color_route;
    REQ.valid && color_hit |=> ROUTE.to_secondary == $past(state_q.legacy_display_route_enable);
  endproperty
  a_color_route: assert property (p_color_route) else $error("colour routing wrong");

  property p_alias;
    REQ.valid && REQ.is_io && !mono_hit && !color_hit && (REQ.addr[9:8] != 2'b00) &&
    state_q.legacy_io_alias_filter |=> !ROUTE.to_secondary;
  endproperty
  a_alias: assert property (p_alias) else $error("alias address sent to secondary");

  property p_io_window;
    REQ.valid && REQ.is_io && !mono_hit && !color_hit && !IO_WINDOW_HIT |=> !ROUTE.to_secondary;
  endproperty
  a_io_window: assert property (p_io_window) else $error("io outside window forwarded");

  property p_abort_read;
    SEC_DONE && SEC_IS_READ && SEC_MASTER_ABORT |=> CPU_RVALID && (CPU_RDATA == bpwc_pkg::MASTER_ABORT_DATA);
  endproperty
  a_abort_read: assert property (p_abort_read) else $error("abort read not all ones");

  property p_abort_write;
    SEC_DONE && !SEC_IS_READ && SEC_MASTER_ABORT |=> !CPU_WR_COMMIT;
  endproperty
  a_abort_write: assert property (p_abort_write) else $error("aborted write committed");

  property p_parity_block;
    SEC_PARITY_ERR && !OTHER_ERR && !state_q.parity_error_report_enable |=> !HUB_ERR_MSG;
  endproperty
  a_parity_block: assert property (p_parity_block) else $error("parity error reported while off");

  property p_parity_report;
    SEC_PARITY_ERR && state_q.parity_error_report_enable |=> HUB_ERR_MSG == $past(GLOBAL_ERROR_MESSAGE_ENABLE);
  endproperty
  a_parity_report: assert property (p_parity_report) else $error("parity message gating wrong");

  property p_base_floor;
    REQ.valid && !REQ.is_io && !mono_hit && !color_hit && (REQ.addr[31:20] == state_q.prefetch_base_field) &&
    (REQ.addr[19:0] == 20'h00000) && (state_q.prefetch_base_field <= state_q.prefetch_limit_field)
    |=> ROUTE.prefetchable;
  endproperty
  a_base_floor: assert property (p_base_floor) else $error("base bottom address missed");

  property p_alias_off;
    REQ.valid && REQ.is_io && !mono_hit && !color_hit && IO_WINDOW_HIT && !state_q.legacy_io_alias_filter
    |=> ROUTE.to_secondary;
  endproperty
  a_alias_off: assert property (p_alias_off) else $error("io window access not forwarded");

  property p_other_err;
    OTHER_ERR && GLOBAL_ERROR_MESSAGE_ENABLE && !state_q.parity_error_report_enable |=> HUB_ERR_MSG;
  endproperty
  a_other_err: assert property (p_other_err) else $error("other error message blocked");

  property p_illegal;
    !state_q.legacy_display_route_enable && MONO_ADAPTER_PRESENT |=> ILLEGAL_DISPLAY_CFG;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal display setting not flagged");

  c_pref_hit: cover property (REQ.valid ##1 ROUTE.prefetchable);
  c_color_sec: cover property (REQ.valid && color_hit && state_q.legacy_display_route_enable);
  c_alias_drop: cover property (REQ.valid && alias_hit && IO_WINDOW_HIT && state_q.legacy_io_alias_filter);
  c_abort: cover property (SEC_DONE && SEC_MASTER_ABORT && SEC_IS_READ);
  c_parity_msg: cover property (SEC_PARITY_ERR ##1 HUB_ERR_MSG);

endmodule // bpwc_top

// *** bpwc_sec_model.sv ***
// Behavioural model of the secondary bus side that finishes transactions for the bridge
`timescale 1ns/100ps

module bpwc_sec_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic rd,
  input wire logic ab,
  input wire logic [31:0] data,
  input wire logic [3:0] wait_cycles,
  output logic done,
  output logic is_rd,
  output logic mabort,
  output logic [31:0] rdata
);
  // ****************************************
  // Transaction timer
  // ****************************************
  logic busy_q;
  logic rd_q;
  logic ab_q;
  logic [31:0] data_q;
  logic [3:0] cnt_q;

  // Qualifiers toggle outside the done cycle so a stale value never passes for a real one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      rd_q <= 1'b0;
      ab_q <= 1'b0;
      data_q <= 32'h0000_0000;
      cnt_q <= 4'h0;
      done <= 1'b0;
      is_rd <= 1'b0;
      mabort <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      is_rd <= ~is_rd;
      mabort <= ~mabort;
      rdata <= ~rdata;
      if (start) begin
        busy_q <= 1'b1;
        rd_q <= rd;
        ab_q <= ab;
        data_q <= data;
        cnt_q <= wait_cycles;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        done <= 1'b1;
        is_rd <= rd_q;
        mabort <= ab_q;
        // An aborted cycle carries junk; the bridge must not pass it on
        rdata <= ab_q ? ~data_q : data_q;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // bpwc_sec_model

// *** testbench.sv ***
// Self-checking testbench for the prefetch window and bridge control block
`timescale 1ns/100ps

module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  bpwc_pkg::bpwc_req_s req = '0;
  bpwc_pkg::bpwc_route_s route;
  logic io_hit = 1'b0;
  logic np_hit = 1'b0;
  logic mono = 1'b0;
  logic illegal;
  logic m_start = 1'b0;
  logic m_rd = 1'b0;
  logic m_ab = 1'b0;
  logic [31:0] m_data = 32'h0000_0000;
  logic [3:0] m_wait = 4'h0;
  logic sec_done;
  logic sec_is_rd;
  logic sec_ab;
  logic [31:0] sec_rdata;
  logic [31:0] cpu_rdata;
  logic cpu_rvalid;
  logic cpu_commit;
  logic par_err = 1'b0;
  logic oth_err = 1'b0;
  logic gen = 1'b0;
  logic hub_msg;
  int err_total = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  bpwc_top u_bpwc_top (.REF_CLK(clk), .RST_N(rst_n), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid), .REQ(req), .IO_WINDOW_HIT(io_hit),
    .NP_WINDOW_HIT(np_hit), .MONO_ADAPTER_PRESENT(mono), .ROUTE(route), .ILLEGAL_DISPLAY_CFG(illegal),
    .SEC_DONE(sec_done), .SEC_IS_READ(sec_is_rd), .SEC_MASTER_ABORT(sec_ab), .SEC_RDATA(sec_rdata),
    .CPU_RDATA(cpu_rdata), .CPU_RVALID(cpu_rvalid), .CPU_WR_COMMIT(cpu_commit), .SEC_PARITY_ERR(par_err),
    .OTHER_ERR(oth_err), .GLOBAL_ERROR_MESSAGE_ENABLE(gen), .HUB_ERR_MSG(hub_msg));

  bpwc_sec_model u_bpwc_sec_model (.clk(clk), .rst_n(rst_n), .start(m_start), .rd(m_rd), .ab(m_ab),
    .data(m_data), .wait_cycles(m_wait), .done(sec_done), .is_rd(sec_is_rd), .mabort(sec_ab), .rdata(sec_rdata));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask

  // Write then read the same byte on consecutive edges, the tightest order allowed
  task automatic cfg_write_read(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
    chk("cfg_rdata", {24'h0, d}, {24'h0, cfg_rdata});
  endtask

  task automatic cfg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
    chk("cfg_rdata", {24'h0, exp}, {24'h0, cfg_rdata});
  endtask

  task automatic route_check(input logic io, input logic [31:0] a, input logic ih, input logic es, input logic ep);
    @(posedge clk);
    req <= {1'b1, io, a};
    io_hit <= ih;
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk("route_valid", 32'h1, {31'h0, route.valid});
    chk("to_secondary", {31'h0, es}, {31'h0, route.to_secondary});
    chk("prefetchable", {31'h0, ep}, {31'h0, route.prefetchable});
  endtask

  task automatic sec_op(input logic rd, input logic ab, input logic [31:0] d, input logic [3:0] w);
    int n;
    n = 0;
    @(posedge clk);
    m_start <= 1'b1;
    m_rd <= rd;
    m_ab <= ab;
    m_data <= d;
    m_wait <= w;
    @(posedge clk);
    m_start <= 1'b0;
    do begin
      #1;
      n++;
      if (sec_done !== 1'b1) @(posedge clk);
    end while (sec_done !== 1'b1 && n < 20);
    @(posedge clk);
    #1;
    chk("cpu_rvalid", {31'h0, rd}, {31'h0, cpu_rvalid});
    chk("cpu_wr_commit", {31'h0, !rd && !ab}, {31'h0, cpu_commit});
    if (rd) chk("cpu_rdata", ab ? 32'hffff_ffff : d, cpu_rdata);
  endtask

  task automatic err_op(input logic par, input logic oth, input logic g, input logic exp);
    @(posedge clk);
    par_err <= par;
    oth_err <= oth;
    gen <= g;
    @(posedge clk);
    par_err <= 1'b0;
    oth_err <= 1'b0;
    #1;
    chk("hub_err_msg", {31'h0, exp}, {31'h0, hub_msg});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    cfg_check(8'h24, 8'hf0);
    cfg_check(8'h25, 8'hff);
    cfg_check(8'h26, 8'h00);
    cfg_check(8'h27, 8'h00);
    cfg_check(8'h3e, 8'h00);
    route_check(1'b0, 32'hfff0_0000, 1'b0, 1'b0, 1'b0);
    route_check(1'b0, 32'h0000_0000, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_window();
    // Window 0x123..0x125 MB stays clear of low memory and of every other window
    cfg_write(8'h24, 8'h3f);
    cfg_write_read(8'h25, 8'h12);
    cfg_write(8'h26, 8'h5f);
    cfg_write(8'h27, 8'h12);
    cfg_check(8'h24, 8'h30);
    cfg_check(8'h26, 8'h50);
    cfg_check(8'h27, 8'h12);
    route_check(1'b0, 32'h122f_ffff, 1'b0, 1'b0, 1'b0);
    route_check(1'b0, 32'h1230_0000, 1'b0, 1'b1, 1'b1);
    route_check(1'b0, 32'h125f_ffff, 1'b0, 1'b1, 1'b1);
    route_check(1'b0, 32'h1260_0000, 1'b0, 1'b0, 1'b0);
    // Outside the prefetch window a plain window hit still forwards, never prefetchable
    @(posedge clk);
    np_hit <= 1'b1;
    route_check(1'b0, 32'h1260_0000, 1'b0, 1'b1, 1'b0);
    @(posedge clk);
    np_hit <= 1'b0;
    route_check(1'b1, 32'h1240_0000, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_display();
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 2; m++) begin
        cfg_write(8'h3e, {4'h0, e[0], 3'h0});
        mono <= m[0];
        route_check(1'b0, 32'h000a_0000, 1'b0, e[0], 1'b0);
        route_check(1'b0, 32'h000b_0000, 1'b0, 1'b0, 1'b0);
        route_check(1'b1, 32'h0000_03c0, 1'b1, e[0], 1'b0);
        route_check(1'b1, 32'h0000_03b0, 1'b1, 1'b0, 1'b0);
        route_check(1'b1, 32'h0000_03bf, 1'b1, 1'b0, 1'b0);
        chk("illegal", {31'h0, !e[0] && m[0]}, {31'h0, illegal});
      end
    end
    @(posedge clk);
    mono <= 1'b0;
  endtask

  task automatic t_ctrl_alias();
    cfg_write(8'h3e, 8'hff);
    cfg_check(8'h3e, 8'h0d);
    for (int f = 0; f < 2; f++) begin
      cfg_write(8'h3e, {5'h0, f[0], 2'h0});
      route_check(1'b1, 32'h0000_1100, 1'b1, !f[0], 1'b0);
      route_check(1'b1, 32'h0000_13ff, 1'b1, !f[0], 1'b0);
      route_check(1'b1, 32'h0000_10ff, 1'b1, 1'b1, 1'b0);
      route_check(1'b1, 32'h0000_1000, 1'b0, 1'b0, 1'b0);
    end
  endtask

  task automatic t_complete_err();
    sec_op(1'b1, 1'b1, 32'h1234_5678, 4'h0);
    sec_op(1'b1, 1'b0, 32'h5a5a_a5a5, 4'h3);
    sec_op(1'b0, 1'b1, 32'h0000_0000, 4'h1);
    sec_op(1'b0, 1'b0, 32'h0000_0000, 4'h2);
    cfg_write(8'h3e, 8'h00);
    err_op(1'b1, 1'b0, 1'b1, 1'b0);
    err_op(1'b0, 1'b1, 1'b1, 1'b1);
    cfg_write(8'h3e, 8'h01);
    err_op(1'b1, 1'b0, 1'b1, 1'b1);
    err_op(1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_window();
    t_display();
    t_ctrl_alias();
    t_complete_err();
    test_done();
  end

  // Tests need well under a thousand cycles; four thousand leaves ample margin
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule // testbench
